// *** hw/vil_pkg.sv ***
package vil_pkg;

  localparam int unsigned NUM_SRC = 3;

  // Request flag bit positions, also the priority order
  localparam int unsigned SRC_EXT = 0;
  localparam int unsigned SRC_T1  = 1;
  localparam int unsigned SRC_T2  = 2;

  // Interrupt control register layout
  localparam int unsigned     CTRL_W       = 4;
  localparam int unsigned     EN_EXT_BIT   = 0;
  localparam int unsigned     EN_SPARE_BIT = 1;
  localparam int unsigned     EN_T1_BIT    = 2;
  localparam int unsigned     EN_T2_BIT    = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  // Vector targets
  localparam int unsigned       VEC_PAGE_W = 4;
  localparam int unsigned       VEC_ADDR_W = 7;
  localparam logic [VEC_PAGE_W-1:0] VEC_PAGE = 4'h1;
  localparam logic [VEC_ADDR_W-1:0] VEC_EXT  = 7'h00;
  localparam logic [VEC_ADDR_W-1:0] VEC_T1   = 7'h04;
  localparam logic [VEC_ADDR_W-1:0] VEC_T2   = 7'h06;

  // Timing in machine cycles and instructions
  localparam logic [1:0] TAKE_MIN_MC      = 2'h2;
  localparam logic [1:0] EI_FURTHER_INSTR = 2'h1;
  localparam logic [1:0] EI_HOLD_LOAD     = EI_FURTHER_INSTR + 2'h1;

  localparam logic [NUM_SRC-1:0] SRC_NONE = 3'h0;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_WAIT
  } vil_state_e;

  // Lowest index wins
  function automatic logic [NUM_SRC-1:0] vil_prio_pick(input logic [NUM_SRC-1:0] req);
    logic [NUM_SRC-1:0] pick;
    pick = SRC_NONE;
    if (req[SRC_EXT]) begin
      pick[SRC_EXT] = 1'b1;
    end else if (req[SRC_T1]) begin
      pick[SRC_T1] = 1'b1;
    end else if (req[SRC_T2]) begin
      pick[SRC_T2] = 1'b1;
    end
    return pick;
  endfunction

  function automatic logic [VEC_ADDR_W-1:0] vil_vec_addr(input logic [NUM_SRC-1:0] onehot);
    logic [VEC_ADDR_W-1:0] addr;
    addr = VEC_EXT;
    if (onehot[SRC_T1]) begin
      addr = VEC_T1;
    end else if (onehot[SRC_T2]) begin
      addr = VEC_T2;
    end
    return addr;
  endfunction

endpackage

// *** hw/vil_pin_sync.sv ***
`timescale 1ns/1ps
module vil_pin_sync
  import vil_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  // Asynchronous pin
  input  wire logic pin_i,
  // One-cycle pulse on every settled level change
  output logic      change_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic known_r;
  logic change_r;
  logic level_nxt;
  logic known_nxt;
  logic change_nxt;

  // First level after reset is learned from the zeroed s2_r and s3_r, so an idle-high pin still raises a request
  always_comb begin
    level_nxt  = level_r;
    known_nxt  = known_r;
    change_nxt = 1'b0;
    if (s2_r == s3_r) begin
      level_nxt = s3_r;
      known_nxt = 1'b1;
      change_nxt = known_r && (s3_r != level_r);
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r     <= 1'b0;
      s2_r     <= 1'b0;
      s3_r     <= 1'b0;
      level_r  <= 1'b0;
      known_r  <= 1'b0;
      change_r <= 1'b0;
    end else begin
      s1_r     <= pin_i;
      s2_r     <= s1_r;
      s3_r     <= s2_r;
      level_r  <= level_nxt;
      known_r  <= known_nxt;
      change_r <= change_nxt;
    end
  end

  assign change_o = change_r;

endmodule // vil_pin_sync

// *** hw/vil_core.sv ***
`timescale 1ns/1ps
module vil_core
  import vil_pkg::*;
(
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rstn_i,
  // Event sources
  input  wire logic                  ext_irq_pin_i,
  input  wire logic                  first_timer_underflow_i,
  input  wire logic                  second_timer_underflow_i,
  // Sequencer timing
  input  wire logic                  machine_cycle_i,
  input  wire logic                  instr_start_i,
  // Instruction strobes
  input  wire logic                  irq_unmask_instr_i,
  input  wire logic                  irq_mask_instr_i,
  input  wire logic                  skip_if_ext_pending_i,
  input  wire logic                  skip_if_first_timer_pending_i,
  input  wire logic                  skip_if_second_timer_pending_i,
  // Control register write from the accumulator
  input  wire logic                  irq_control_wr_i,
  input  wire logic [CTRL_W-1:0]     irq_control_wdata_i,
  // Register and flag views
  output logic [CTRL_W-1:0]          irq_control_reg_o,
  output logic                       global_irq_enable_flag_o,
  output logic                       ext_request_flag_o,
  output logic                       first_timer_request_flag_o,
  output logic                       second_timer_request_flag_o,
  // Answers to the sequencer
  output logic                       skip_o,
  output logic                       irq_take_o,
  output logic [VEC_PAGE_W-1:0]      irq_vector_page_o,
  output logic [VEC_ADDR_W-1:0]      irq_vector_addr_o
);

  logic                  ext_change;
  logic [CTRL_W-1:0]     ctrl_r;
  logic [CTRL_W-1:0]     ctrl_nxt;
  logic                  gie_r;
  logic                  gie_nxt;
  logic [1:0]            ei_hold_r;
  logic [1:0]            ei_hold_nxt;
  logic [NUM_SRC-1:0]    flags_r;
  logic [NUM_SRC-1:0]    flags_nxt;
  vil_state_e            state_r;
  vil_state_e            state_nxt;
  logic [1:0]            wait_cnt_r;
  logic [1:0]            wait_cnt_nxt;
  logic                  skip_r;
  logic                  skip_nxt;
  logic                  take_r;
  logic                  take_nxt;
  logic [VEC_ADDR_W-1:0] vec_r;
  logic [VEC_ADDR_W-1:0] vec_nxt;
  logic [NUM_SRC-1:0]    taken_src_r;
  logic [NUM_SRC-1:0]    taken_src_nxt;
  logic [VEC_PAGE_W-1:0] page_r;
  logic [VEC_PAGE_W-1:0] page_nxt;

  logic [NUM_SRC-1:0]    src_en;
  logic [NUM_SRC-1:0]    set_vec;
  logic [NUM_SRC-1:0]    skip_req;
  logic [NUM_SRC-1:0]    skip_hit;
  logic [NUM_SRC-1:0]    en_pend;
  logic [NUM_SRC-1:0]    pick;
  logic [NUM_SRC-1:0]    clr_vec;
  logic                  boundary;
  logic                  gie_eff;
  logic                  cond;
  logic                  fire;

  vil_pin_sync u_pin_sync (
    .mclk_i   (mclk_i),
    .rstn_i   (rstn_i),
    .pin_i    (ext_irq_pin_i),
    .change_o (ext_change)
  );

  always_comb begin
    src_en            = SRC_NONE;
    src_en[SRC_EXT]   = ctrl_r[EN_EXT_BIT];
    src_en[SRC_T1]    = ctrl_r[EN_T1_BIT];
    src_en[SRC_T2]    = ctrl_r[EN_T2_BIT];
    set_vec           = SRC_NONE;
    set_vec[SRC_EXT]  = ext_change;
    set_vec[SRC_T1]   = first_timer_underflow_i;
    set_vec[SRC_T2]   = second_timer_underflow_i;
    skip_req          = SRC_NONE;
    skip_req[SRC_EXT] = skip_if_ext_pending_i;
    skip_req[SRC_T1]  = skip_if_first_timer_pending_i;
    skip_req[SRC_T2]  = skip_if_second_timer_pending_i;
  end

  // Skips only act on sources whose interrupt is disabled
  assign skip_hit = skip_req & flags_r & ~src_en;
  assign en_pend  = flags_r & src_en;
  assign pick     = vil_prio_pick(en_pend);
  assign boundary = machine_cycle_i && instr_start_i;
  // Unmask is withheld until the following instruction has completed
  assign gie_eff  = gie_r && (ei_hold_r == 2'h0);
  assign cond     = gie_eff && (|en_pend);

  // Acceptance sequencer
  always_comb begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    fire         = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        wait_cnt_nxt = 2'h0;
        if (cond) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!cond) begin
          state_nxt = ST_IDLE;
        end else if (boundary && (wait_cnt_r >= TAKE_MIN_MC)) begin
          fire      = 1'b1;
          state_nxt = ST_IDLE;
        end else if (machine_cycle_i && (wait_cnt_r < TAKE_MIN_MC)) begin
          wait_cnt_nxt = wait_cnt_r + 2'h1;
        end
      end
    endcase
  end

  // Flags, global enable, control register and answers
  always_comb begin
    clr_vec       = skip_hit;
    if (fire) begin
      clr_vec = clr_vec | pick;
    end
    // A new event in the clearing cycle is kept
    flags_nxt     = set_vec | (flags_r & ~clr_vec);
    ctrl_nxt      = irq_control_wr_i ? irq_control_wdata_i : ctrl_r;
    gie_nxt       = gie_r;
    ei_hold_nxt   = ei_hold_r;
    if (irq_unmask_instr_i) begin
      gie_nxt     = 1'b1;
      ei_hold_nxt = EI_HOLD_LOAD;
    end else begin
      if (irq_mask_instr_i || fire) begin
        gie_nxt = 1'b0;
      end
      if (boundary && (ei_hold_r != 2'h0)) begin
        ei_hold_nxt = ei_hold_r - 2'h1;
      end
    end
    skip_nxt      = |skip_hit;
    take_nxt      = fire;
    vec_nxt       = fire ? vil_vec_addr(pick) : vec_r;
    taken_src_nxt = fire ? pick : taken_src_r;
    page_nxt      = VEC_PAGE;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r     <= ST_IDLE;
      wait_cnt_r  <= 2'h0;
      ctrl_r      <= CTRL_RESET;
      gie_r       <= 1'b0;
      ei_hold_r   <= 2'h0;
      flags_r     <= SRC_NONE;
      skip_r      <= 1'b0;
      take_r      <= 1'b0;
      vec_r       <= VEC_EXT;
      taken_src_r <= SRC_NONE;
      page_r      <= VEC_PAGE;
    end else begin
      state_r     <= state_nxt;
      wait_cnt_r  <= wait_cnt_nxt;
      ctrl_r      <= ctrl_nxt;
      gie_r       <= gie_nxt;
      ei_hold_r   <= ei_hold_nxt;
      flags_r     <= flags_nxt;
      skip_r      <= skip_nxt;
      take_r      <= take_nxt;
      vec_r       <= vec_nxt;
      taken_src_r <= taken_src_nxt;
      page_r      <= page_nxt;
    end
  end

  assign irq_control_reg_o           = ctrl_r;
  assign global_irq_enable_flag_o    = gie_r;
  assign ext_request_flag_o          = flags_r[SRC_EXT];
  assign first_timer_request_flag_o  = flags_r[SRC_T1];
  assign second_timer_request_flag_o = flags_r[SRC_T2];
  assign skip_o                      = skip_r;
  assign irq_take_o                  = take_r;
  // Page never changes, but sits in a flop like every other output
  assign irq_vector_page_o           = page_r;
  assign irq_vector_addr_o           = vec_r;

  a_vector_map: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    irq_take_o |-> ((taken_src_r[SRC_EXT] && irq_vector_addr_o == VEC_EXT) ||
                    (taken_src_r[SRC_T1] && irq_vector_addr_o == VEC_T1) ||
                    (taken_src_r[SRC_T2] && irq_vector_addr_o == VEC_T2)))
    else $error("vector address does not match serviced source");

  a_take_all_three: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    irq_take_o |-> $past(gie_r) && ($past(ei_hold_r) == 2'h0) &&
                   (|($past(flags_r) & $past(src_en) & taken_src_r)))
    else $error("interrupt taken without all three conditions");

  a_mask_clears: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (irq_mask_instr_i && !irq_unmask_instr_i) |=> !global_irq_enable_flag_o)
    else $error("mask instruction left global flag set");

  a_take_clears_gie: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (irq_take_o && !$past(irq_unmask_instr_i)) |-> !global_irq_enable_flag_o)
    else $error("global flag still set after interrupt taken");

  a_skip_polls: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (skip_if_first_timer_pending_i && first_timer_request_flag_o) |=>
      (skip_o == !$past(ctrl_r[EN_T1_BIT])))
    else $error("skip answer disagrees with enable bit");

  a_flag_sets: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    second_timer_underflow_i |=> second_timer_request_flag_o)
    else $error("underflow did not set request flag");

  a_flag_holds: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (ext_request_flag_o && !clr_vec[SRC_EXT]) |=> ext_request_flag_o)
    else $error("request flag dropped without a clear");

  a_priority_order: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    fire |-> (en_pend[SRC_EXT] ? pick[SRC_EXT] :
              en_pend[SRC_T1] ? pick[SRC_T1] : pick[SRC_T2]))
    else $error("lower priority source serviced first");

  a_take_latency: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    fire |-> boundary && (wait_cnt_r == TAKE_MIN_MC) && $past(cond))
    else $error("interrupt taken too early or off a boundary");

  a_unmask_delay: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    irq_unmask_instr_i |=> !cond && !fire)
    else $error("unmask took effect without a further instruction");

  a_unmask_sets: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    irq_unmask_instr_i |=> global_irq_enable_flag_o)
    else $error("unmask instruction left global flag clear");

  a_take_one_pulse: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    irq_take_o |=> !irq_take_o)
    else $error("interrupt taken twice in a row");

  a_skip_clears_flag: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (skip_if_first_timer_pending_i && first_timer_request_flag_o &&
     !irq_control_reg_o[EN_T1_BIT] && !first_timer_underflow_i) |=>
      !first_timer_request_flag_o)
    else $error("successful skip left request flag set");

  a_enable_mutes_skip: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (irq_control_reg_o[EN_EXT_BIT] && irq_control_reg_o[EN_T1_BIT] &&
     irq_control_reg_o[EN_T2_BIT]) |=> !skip_o)
    else $error("skip answered while every source is enabled");

  a_timer_flag_sets: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    first_timer_underflow_i |=> first_timer_request_flag_o)
    else $error("first timer underflow did not set request flag");

  a_pin_sets_flag: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    ext_change |=> ext_request_flag_o)
    else $error("pin level change did not set request flag");

  a_ctrl_write: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    irq_control_wr_i |=> (irq_control_reg_o == $past(irq_control_wdata_i)))
    else $error("control register write was lost");

  a_take_clears_flag: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (irq_take_o && taken_src_r[SRC_T1] && !$past(first_timer_underflow_i)) |->
      !first_timer_request_flag_o)
    else $error("serviced request flag still set");

  a_wait_bounded: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (wait_cnt_r <= TAKE_MIN_MC))
    else $error("machine cycle count ran past its limit");

  a_page_fixed: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (irq_vector_page_o == VEC_PAGE))
    else $error("vector page is not the fixed page");

  a_take_on_boundary: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    irq_take_o |-> $past(boundary))
    else $error("interrupt accepted off an instruction boundary");

  a_mask_blocks_take: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    !global_irq_enable_flag_o |-> !fire)
    else $error("interrupt accepted while globally masked");

endmodule // vil_core

// *** bench/vil_seq_model.sv ***
`timescale 1ns/1ps
module vil_seq_model #(
  parameter int MC_PERIOD = 4
) (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  output logic      machine_cycle_o,
  output logic      instr_start_o
);
  logic [3:0] cnt_r;
  logic [1:0] mc_idx_r;
  // Every fourth machine cycle is the second half of a two-cycle instruction
  assign instr_start_o   = (mc_idx_r != 2'h3);
  assign machine_cycle_o = rstn_i && (cnt_r == 4'h0);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r    <= 4'h0;
      mc_idx_r <= 2'h0;
    end else begin
      cnt_r <= (cnt_r == 4'(MC_PERIOD - 1)) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r == 4'h0) begin
        mc_idx_r <= mc_idx_r + 2'h1;
      end
    end
  end
endmodule // vil_seq_model

// *** bench/vil_core_tb.sv ***
`timescale 1ns/1ps
module vil_core_tb;
  import vil_pkg::*;
  logic                  mclk_i, rstn_i, pin, mc, ist, wr, gie, f0, f1, f2, skp, tk;
  logic [6:0]            str;
  logic [3:0]            wd;
  logic [CTRL_W-1:0]     ctl;
  logic [VEC_PAGE_W-1:0] pg;
  logic [VEC_ADDR_W-1:0] va;
  logic [8:0]            q[$];
  int                    mismatches, total_checks, seed;
  wire [2:0]             fl = {f2, f1, f0};

  vil_seq_model SEQ (.mclk_i(mclk_i), .rstn_i(rstn_i), .machine_cycle_o(mc), .instr_start_o(ist));
  vil_core DUT (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ext_irq_pin_i(pin),
    .first_timer_underflow_i(str[0]), .second_timer_underflow_i(str[1]),
    .machine_cycle_i(mc), .instr_start_i(ist),
    .irq_unmask_instr_i(str[2]), .irq_mask_instr_i(str[3]),
    .skip_if_ext_pending_i(str[4]), .skip_if_first_timer_pending_i(str[5]),
    .skip_if_second_timer_pending_i(str[6]),
    .irq_control_wr_i(wr), .irq_control_wdata_i(wd), .irq_control_reg_o(ctl),
    .global_irq_enable_flag_o(gie), .ext_request_flag_o(f0),
    .first_timer_request_flag_o(f1), .second_timer_request_flag_o(f2),
    .skip_o(skp), .irq_take_o(tk), .irq_vector_page_o(pg), .irq_vector_addr_o(va));

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Strobes go out right after a machine-cycle start so unmask never sits on a boundary
  task automatic pulse(input int b);
    @(posedge mclk_i iff mc);
    str <= 7'(1 << b);
    @(posedge mclk_i);
    str <= 7'h00;
    #1;
  endtask

  task automatic wctl(input logic [3:0] d);
    @(posedge mclk_i);
    wr <= 1'b1;
    wd <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
    @(posedge mclk_i);
    #1;
  endtask

  task automatic waitq(input int lo);
    int n;
    n = 0;
    while (q.size() != 0 && n < 60) begin
      @(posedge mclk_i);
      n++;
    end
    chk(9'(n >= lo && n <= 40), 9'h001);
  endtask

  task automatic take(input logic [6:0] v);
    q.push_back({2'b01, v});
    pulse(2);
    waitq(8);
    chk(9'(gie), 9'h000);
  endtask

  // Result watcher: every skip or take must match the oldest note
  always @(posedge mclk_i) begin
    if (skp === 1'b1 || tk === 1'b1) begin
      chk(skp ? 9'h100 : {2'b01, va}, q.size() ? q.pop_front() : 9'h1ff);
    end
  end

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  initial begin
    #100_000;
    mismatches++;
    stop_test();
  end

  initial begin
    logic [3:0] d;
    seed = 21173;
    rstn_i = 1'b0;
    pin = 1'b0;
    str = 7'h00;
    wr = 1'b0;
    wd = 4'h0;
    repeat (2) @(posedge mclk_i);
    #3 rstn_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    #1;
    chk({1'b0, gie, ctl, fl}, 9'h000);
    chk(9'(pg), 9'(VEC_PAGE));
    repeat (6) begin
      d = 4'($random(seed));
      wctl(d);
      chk(9'(ctl), 9'(d));
    end
    wctl(4'h0);
    pulse(0);
    pulse(1);
    @(posedge mclk_i) pin <= 1'b1;
    repeat (10) @(posedge mclk_i);
    chk(9'(fl), 9'h007);
    q.push_back(9'h100);
    pulse(5);
    repeat (3) @(posedge mclk_i);
    chk(9'(fl), 9'h005);
    wctl(4'h1);
    pulse(4);
    repeat (3) @(posedge mclk_i);
    chk(9'(fl), 9'h005);
    pulse(0);
    wctl(4'hd);
    take(VEC_EXT);
    chk(9'(fl), 9'h006);
    take(VEC_T1);
    take(VEC_T2);
    chk(9'(fl), 9'h000);
    // Mask before the unmask takes effect must keep the request pending
    pulse(1);
    pulse(2);
    chk(9'(gie), 9'h001);
    pulse(3);
    chk(9'(gie), 9'h000);
    repeat (40) @(posedge mclk_i);
    chk(9'(fl), 9'h004);
    wctl(4'h0);
    pulse(2);
    repeat (40) @(posedge mclk_i);
    chk(9'(fl), 9'h004);
    q.push_back(9'h100);
    pulse(6);
    repeat (3) @(posedge mclk_i);
    chk(9'(fl), 9'h000);
    pulse(1);
    q.push_back({2'b01, VEC_T2});
    wctl(4'h8);
    waitq(2);
    chk(9'({gie, fl}), 9'h000);
    stop_test();
  end
endmodule // vil_core_tb
